// *** logic/sca_cfg.svh ***
// Purpose: Constants for the setup command interpreter
// Assumes: Characters arrive one per rx_valid pulse, upper case ASCII
// Notes:   Offsets, characters and reset values are defined here
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH
// ==========================================
// Framing characters
`define SCA_CH_CR      8'h0D
`define SCA_CH_DOLLAR  8'h24
`define SCA_CH_HASH    8'h23
`define SCA_CH_NUL     8'h00
// ==========================================
// Command letters
`define SCA_CH_W       8'h57
`define SCA_CH_E       8'h45
`define SCA_CH_S       8'h53
`define SCA_CH_U       8'h55
`define SCA_CH_R       8'h52
// ==========================================
// Hex digit ranges
`define SCA_CH_0       8'h30
`define SCA_CH_9       8'h39
`define SCA_CH_A       8'h41
`define SCA_CH_F       8'h46
`define SCA_HEX_ADJ    8'h37
// ==========================================
// Setup record layout
`define SCA_OPND_LEN   4'h8
`define SCA_CNT_MAX    4'h9
`define SCA_LET_MAX    4'h3
`define SCA_ADDR_HI    31
`define SCA_ADDR_LO    24
`define SCA_ADDR_MSB   31
`define SCA_SETUP_INIT 32'h3107_0102
`endif

// *** logic/sca_pkg.sv ***
// Purpose: Types for the setup command interpreter
// Assumes: Used with sca_cfg.svh
// Notes:   Parser states are one-hot
package sca_pkg;
   // ==========================================
   // Parser states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_CMD  = 5'h04,
      ST_OPND = 5'h08,
      ST_SKIP = 5'h10
   } sca_state_t;
   // ==========================================
   // Recognised commands
   typedef enum logic [2:0] {
      K_NONE    = 3'h0,
      K_WE      = 3'h1,
      K_SETUP   = 3'h2,
      K_RD_ALT  = 3'h3,
      K_RD_FULL = 3'h4,
      K_BAD     = 3'h5
   } sca_kind_t;
   // ==========================================
   // Response codes
   typedef enum logic [2:0] {
      RSP_OK     = 3'h0,
      RSP_SYNTAX = 3'h1,
      RSP_ADDR   = 3'h2,
      RSP_WPROT  = 3'h3,
      RSP_CMDERR = 3'h4
   } sca_rsp_t;
endpackage

// *** logic/sca_setup_cmd.sv ***
// Purpose: Parses write-enable, setup-write and setup-read commands
// Assumes: Core logic delivers received characters as rx_valid pulses
// Notes:   setup_r mirrors the nonvolatile record; nvm_wr stores it
`timescale 1ns/1ps
`include "sca_cfg.svh"

// Function
// R1: Setup-write stores four-byte record to memory
// R2: Operand exactly eight hex characters else syntax
// R3: Each byte two hex characters, high first
// R4: Bit 7 is most significant bit
// R5: Setup-write executes only with pending enable
// R6: Non-hex operand character aborts with syntax
// R7: Setup byte 1 is polling address
// R8: New address takes effect after write
// R9: Address bit 7 set gives address error
// R10: Addresses 00, 0D, 24, 23 rejected
// R11: Host should pick addresses 21 to 7E
// R12: Read-setup returns stored record anytime
// R13: Host should read setup before writing
// R14: Successful protected command clears write enable
// R15: Protected command without enable gets refused
// R16: Other errors keep write enable pending
// R17: Commit only after all checks pass
module sca_setup_cmd
   import sca_pkg::*;
#(
   parameter logic [31:0] SETUP_INIT = `SCA_SETUP_INIT
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_char,
   output logic             rsp_valid,
   output sca_rsp_t         rsp_code,
   output logic             rsp_read,
   output logic [31:0]      rsp_data,
   output logic             nvm_wr,
   output logic [31:0]      nvm_data,
   output logic [7:0]       setup_address_byte,
   output logic             we_pending
);

   // ==========================================
   // Decoding helpers
   // Returns {valid, nibble} for an upper case hex character
   function automatic logic [4:0] sca_hex(input logic [7:0] c);
      logic [7:0] t;
      t = 8'h00;
      if (c >= `SCA_CH_0 && c <= `SCA_CH_9) begin
         t = c - `SCA_CH_0;
         return {1'b1, t[3:0]};
      end else if (c >= `SCA_CH_A && c <= `SCA_CH_F) begin
         t = c - `SCA_HEX_ADJ;
         return {1'b1, t[3:0]};
      end
      return 5'h00;
   endfunction

   // True when a byte may not serve as polling address
   function automatic logic sca_bad_addr(input logic [7:0] a);
      return a[7] || a == `SCA_CH_NUL || a == `SCA_CH_CR
             || a == `SCA_CH_DOLLAR || a == `SCA_CH_HASH;
   endfunction

   // ==========================================
   // State
   sca_state_t  st_r,     st_nxt;
   sca_kind_t   kind_r,   kind_nxt;
   logic [7:0]  let_r,    let_nxt;
   logic [3:0]  cnt_r,    cnt_nxt;
   logic [31:0] opnd_r,   opnd_nxt;
   logic [31:0] setup_r,  setup_nxt;
   logic        we_r,     we_nxt;
   logic        rv_r,     rv_nxt;
   sca_rsp_t    rc_r,     rc_nxt;
   logic        rd_r,     rd_nxt;
   logic [31:0] rdat_r,   rdat_nxt;
   logic        nw_r,     nw_nxt;
   logic [4:0]  hx;
   logic        at_cr;
   logic        su_eval;
   logic        commit;
   logic        rd_eval;

   // Character classification
   assign hx      = sca_hex(rx_char);
   assign at_cr   = rx_valid && rx_char == `SCA_CH_CR;
   // Setup-write has enable and full operand at line end
   assign su_eval = at_cr && st_r == ST_OPND && we_r && cnt_r == `SCA_OPND_LEN; // [R2] [R5]
   // Store only when the address byte is legal too
   assign commit  = su_eval && !sca_bad_addr(opnd_r[`SCA_ADDR_HI:`SCA_ADDR_LO]); // [R17]
   assign rd_eval = at_cr && st_r == ST_CMD && (kind_r == K_RD_ALT || kind_r == K_RD_FULL);

   // ==========================================
   // Parser next state
   always_comb begin
      st_nxt    = st_r;
      kind_nxt  = kind_r;
      let_nxt   = let_r;
      cnt_nxt   = cnt_r;
      opnd_nxt  = opnd_r;
      setup_nxt = setup_r;
      we_nxt    = we_r;
      rv_nxt    = 1'b0;
      rc_nxt    = rc_r;
      rd_nxt    = 1'b0;
      rdat_nxt  = rdat_r;
      nw_nxt    = 1'b0;
      if (rx_valid) begin
         unique case (st_r)
            ST_IDLE: begin
               // Either prompt opens a line
               if (rx_char == `SCA_CH_DOLLAR || rx_char == `SCA_CH_HASH) begin
                  st_nxt = ST_ADDR;
               end
            end
            ST_ADDR: begin
               // Live address byte decides who answers
               if (rx_char == setup_r[`SCA_ADDR_HI:`SCA_ADDR_LO]) begin // [R7] [R8]
                  st_nxt   = ST_CMD;
                  kind_nxt = K_NONE;
                  cnt_nxt  = 4'h0;
               end else if (rx_char == `SCA_CH_CR) begin
                  st_nxt = ST_IDLE;
               end else begin
                  st_nxt = ST_SKIP;
               end
            end
            ST_CMD: begin
               if (at_cr) begin
                  st_nxt = ST_IDLE;
                  rv_nxt = 1'b1;
                  unique case (kind_r)
                     K_WE: begin
                        rc_nxt = RSP_OK;
                        we_nxt = 1'b1;
                     end
                     K_RD_ALT, K_RD_FULL: begin
                        // Record returned whatever the enable state
                        rc_nxt   = RSP_OK; // [R12]
                        rd_nxt   = 1'b1;
                        rdat_nxt = setup_r;
                        we_nxt   = 1'b0;
                     end
                     default: rc_nxt = RSP_CMDERR;
                  endcase
               end else begin
                  let_nxt = rx_char;
                  if (cnt_r != `SCA_LET_MAX) begin
                     cnt_nxt = cnt_r + 4'h1;
                  end
                  if (cnt_r == 4'h0) begin
                     kind_nxt = K_NONE;
                  end else if (cnt_r == 4'h1) begin
                     if (let_r == `SCA_CH_W && rx_char == `SCA_CH_E) begin
                        kind_nxt = K_WE;
                     end else if (let_r == `SCA_CH_R && rx_char == `SCA_CH_S) begin
                        kind_nxt = K_RD_ALT;
                     end else if (let_r == `SCA_CH_S && rx_char == `SCA_CH_U) begin
                        // Operand digits follow directly
                        kind_nxt = K_SETUP;
                        st_nxt   = ST_OPND;
                        cnt_nxt  = 4'h0;
                        opnd_nxt = 32'h0000_0000;
                     end else begin
                        kind_nxt = K_BAD;
                     end
                  end else if (kind_r == K_RD_ALT && cnt_r == 4'h2 && rx_char == `SCA_CH_U) begin
                     kind_nxt = K_RD_FULL;
                  end else begin
                     kind_nxt = K_BAD;
                  end
               end
            end
            ST_OPND: begin
               if (at_cr) begin
                  st_nxt = ST_IDLE;
                  rv_nxt = 1'b1;
                  if (!we_r) begin
                     rc_nxt = RSP_WPROT; // [R15]
                  end else if (cnt_r != `SCA_OPND_LEN) begin
                     rc_nxt = RSP_SYNTAX; // [R2] [R16]
                  end else if (!commit) begin
                     rc_nxt = RSP_ADDR; // [R9] [R10] [R16]
                  end else begin
                     // All checks passed: store and drop the enable
                     rc_nxt    = RSP_OK; // [R1] [R17]
                     setup_nxt = opnd_r;
                     nw_nxt    = 1'b1;
                     we_nxt    = 1'b0; // [R14]
                  end
               end else if (!hx[4]) begin
                  // Abort now, swallow rest of line
                  st_nxt = ST_SKIP; // [R6]
                  rv_nxt = 1'b1;
                  rc_nxt = RSP_SYNTAX;
               end else begin
                  // Shift in high nibble first, MSB at bit 31
                  opnd_nxt = {opnd_r[27:0], hx[3:0]}; // [R3] [R4]
                  if (cnt_r != `SCA_CNT_MAX) begin
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            ST_SKIP: begin
               if (at_cr) begin
                  st_nxt = ST_IDLE;
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   // Register the parser and setup record
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r    <= ST_IDLE;
         kind_r  <= K_NONE;
         let_r   <= 8'h00;
         cnt_r   <= 4'h0;
         opnd_r  <= 32'h0000_0000;
         setup_r <= SETUP_INIT;
         we_r    <= 1'b0;
         rv_r    <= 1'b0;
         rc_r    <= RSP_OK;
         rd_r    <= 1'b0;
         rdat_r  <= 32'h0000_0000;
         nw_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         kind_r  <= kind_nxt;
         let_r   <= let_nxt;
         cnt_r   <= cnt_nxt;
         opnd_r  <= opnd_nxt;
         setup_r <= setup_nxt;
         we_r    <= we_nxt;
         rv_r    <= rv_nxt;
         rc_r    <= rc_nxt;
         rd_r    <= rd_nxt;
         rdat_r  <= rdat_nxt;
         nw_r    <= nw_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign rsp_valid          = rv_r;
   assign rsp_code           = rc_r;
   assign rsp_read           = rd_r;
   assign rsp_data           = rdat_r;
   assign nvm_wr             = nw_r;
   assign nvm_data           = setup_r;
   assign setup_address_byte = setup_r[`SCA_ADDR_HI:`SCA_ADDR_LO];
   assign we_pending         = we_r;

   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   commit_store_a: assert property (commit |=> nw_r && setup_r == $past(opnd_r)) // [R1]
      else $error("record not stored on commit");
   len_check_a: assert property (at_cr && st_r == ST_OPND && we_r // [R2]
      && cnt_r != `SCA_OPND_LEN |=> rv_r && rc_r == RSP_SYNTAX && $stable(setup_r))
      else $error("bad operand length not refused");
   nibble_order_a: assert property (rx_valid && st_r == ST_OPND && hx[4] // [R3]
      |=> opnd_r[3:0] == $past(hx[3:0]) && opnd_r[7:4] == $past(opnd_r[3:0]))
      else $error("nibble order wrong");
   addr_field_a: assert property (commit |=> setup_address_byte == $past(opnd_r[31:24])) // [R4]
      else $error("address byte taken from wrong bits");
   needs_enable_a: assert property (nw_r |-> $past(we_r)) // [R5]
      else $error("write without pending enable");
   hex_abort_a: assert property (rx_valid && st_r == ST_OPND && !hx[4] && !at_cr // [R6]
      |=> rv_r && rc_r == RSP_SYNTAX && st_r == ST_SKIP)
      else $error("non-hex character not aborted");
   addr_other_a: assert property (rx_valid && st_r == ST_ADDR && !at_cr // [R7]
      && rx_char != setup_address_byte |=> st_r == ST_SKIP)
      else $error("foreign address answered");
   addr_match_a: assert property (rx_valid && st_r == ST_ADDR // [R8]
      && rx_char == setup_address_byte |=> st_r == ST_CMD)
      else $error("own address ignored");
   addr_msb_a: assert property (su_eval && opnd_r[31] |=> rc_r == RSP_ADDR && !nw_r) // [R9]
      else $error("address bit 7 accepted");
   addr_illegal_a: assert property (su_eval && sca_bad_addr(opnd_r[31:24]) // [R10]
      |=> rv_r && rc_r == RSP_ADDR && $stable(setup_r))
      else $error("illegal address accepted");
   read_back_a: assert property (rd_eval |=> rv_r && rd_r && rsp_data == $past(setup_r)) // [R12]
      else $error("read-setup data wrong");
   we_clear_a: assert property (commit |=> !we_r) // [R14]
      else $error("enable kept after write");
   wprot_a: assert property (at_cr && st_r == ST_OPND && !we_r // [R15]
      |=> rv_r && rc_r == RSP_WPROT && !nw_r)
      else $error("protected write not refused");
   we_hold_a: assert property ($past(we_r) && rv_r && rc_r != RSP_OK |-> we_r) // [R16]
      else $error("enable lost on error");
   ok_after_a: assert property (nw_r |-> rv_r && rc_r == RSP_OK) // [R17]
      else $error("store without success answer");

   write_ok_c: cover property (commit ##1 nw_r);
   addr_err_c: cover property (su_eval && !commit);
   read_c: cover property (rd_eval);
   abort_c: cover property (st_r == ST_OPND ##1 st_r == ST_SKIP);

endmodule

// *** sim/sca_host_model.sv ***
// Purpose: Host terminal model that sends command lines one character per clock
// Assumes: Upper case ASCII lines, CR appended by the model
// Notes:   rx_char idles at FF before the first line, then at F2, the inverse of CR
`timescale 1ns/1ps
// ==========================================
// Host side of the character stream
module sca_host_model (
   input  wire logic       mclk,
   output logic            rx_valid,
   output logic [7:0]      rx_char
);
   // Idle line at time zero
   initial begin
      rx_valid = 1'b0;
      rx_char  = 8'hFF;
   end
   // Sends one line, back to back characters, then CR
   task automatic send_line(input string s);
      int i;
      for (i = 0; i < s.len(); i++) begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_char  <= s[i];
      end
      @(posedge mclk);
      rx_char <= 8'h0D;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_char  <= 8'hF2; // Inverse of CR, no stale value
   endtask
endmodule

// *** sim/setup_command_address_config_bench.sv ***
// Purpose: Self-checking bench for the setup command interpreter
// Assumes: Host model drives the character stream
// Notes:   A monitor records every answer and every memory store
`timescale 1ns/1ps
// ==========================================
// Bench top
module setup_command_address_config_bench;
   import sca_pkg::*;
   localparam logic [31:0] INIT = 32'h3107_0102;
   logic        mclk;
   logic        rst;
   logic        rx_valid;
   logic [7:0]  rx_char;
   logic        rsp_valid;
   sca_rsp_t    rsp_code;
   logic        rsp_read;
   logic [31:0] rsp_data;
   logic        nvm_wr;
   logic [31:0] nvm_data;
   logic [7:0]  setup_address_byte;
   logic        we_pending;
   int          err_count = 0;
   int          checked = 0;
   int          rsp_count = 0;
   int          nvm_count = 0;
   logic [2:0]  last_code = 3'h0;
   logic        last_read = 1'b0;
   logic [31:0] last_data = 32'h0000_0000;
   sca_setup_cmd #(.SETUP_INIT(INIT)) i_dut (
      .mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_char(rx_char),
      .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_read(rsp_read),
      .rsp_data(rsp_data), .nvm_wr(nvm_wr), .nvm_data(nvm_data),
      .setup_address_byte(setup_address_byte), .we_pending(we_pending)
   );
   sca_host_model i_host (.mclk(mclk), .rx_valid(rx_valid), .rx_char(rx_char));
   // Clock at 200 MHz
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Records answers and stores
   always @(posedge mclk) begin
      if (rsp_valid === 1'b1) begin
         rsp_count++;
         last_code = rsp_code;
         last_read = rsp_read;
         last_data = rsp_data;
      end
      if (nvm_wr === 1'b1) nvm_count++;
   end
   // ==========================================
   // Shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("Counts: %0d checks, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Sends a line, checks answer count, code and store count
   task automatic cmd(input string s, input logic [2:0] code, input int n, input int w);
      int c0;
      int w0;
      c0 = rsp_count;
      w0 = nvm_count;
      i_host.send_line(s);
      repeat (3) @(posedge mclk);
      check({"answers ", s}, 32'(rsp_count - c0), 32'(n));
      check({"stores ", s}, 32'(nvm_count - w0), 32'(w));
      if (n > 0) check({"code ", s}, {29'h0, last_code}, {29'h0, code});
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      check("reset record", nvm_data, INIT);
      check("reset address", {24'h0, setup_address_byte}, 32'h0000_0031);
      check("reset enable", {31'h0, we_pending}, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_wprot();
      cmd("$1SU32070102", RSP_WPROT, 1, 0);
      check("record kept", nvm_data, INIT);
      $display("test write protect done");
   endtask
   task automatic t_write();
      cmd("$1RS", RSP_OK, 1, 0);
      check("read before write", last_data, INIT);
      cmd("$1WE", RSP_OK, 1, 0);
      check("enable set", {31'h0, we_pending}, 32'h0000_0001);
      cmd("$1SU32070102", RSP_OK, 1, 1);
      check("record stored", nvm_data, 32'h3207_0102);
      check("new address", {24'h0, setup_address_byte}, 32'h0000_0032);
      check("enable cleared", {31'h0, we_pending}, 32'h0000_0000);
      check("read flag clear", {31'h0, last_read}, 32'h0000_0000);
      cmd("$1SU31070102", RSP_OK, 0, 0);
      $display("test write done");
   endtask
   task automatic t_read();
      cmd("$1RS", RSP_OK, 0, 0);
      cmd("$2RSU", RSP_OK, 1, 0);
      check("read flag", {31'h0, last_read}, 32'h0000_0001);
      check("read data", last_data, 32'h3207_0102);
      cmd("$2RS", RSP_OK, 1, 0);
      check("alias data", last_data, 32'h3207_0102);
      cmd("#2RSU", RSP_OK, 1, 0);
      check("second prompt data", last_data, 32'h3207_0102);
      $display("test read done");
   endtask
   task automatic t_syntax();
      cmd("$2WE", RSP_OK, 1, 0);
      cmd("$2SU3207010", RSP_SYNTAX, 1, 0);
      cmd("$2SU320701020", RSP_SYNTAX, 1, 0);
      cmd("$2SU32X70102", RSP_SYNTAX, 1, 0);
      cmd("$2SU32a70102", RSP_SYNTAX, 1, 0);
      cmd("$2QQ", RSP_CMDERR, 1, 0);
      check("error read flag", {31'h0, last_read}, 32'h0000_0000);
      check("record kept", nvm_data, 32'h3207_0102);
      check("enable kept", {31'h0, we_pending}, 32'h0000_0001);
      $display("test syntax done");
   endtask
   task automatic t_badaddr();
      string a [5];
      int    i;
      a = '{"00", "0D", "24", "23", "B2"};
      for (i = 0; i < 5; i++) begin
         cmd({"$2SU", a[i], "070102"}, RSP_ADDR, 1, 0);
         check("record kept", nvm_data, 32'h3207_0102);
      end
      check("enable kept", {31'h0, we_pending}, 32'h0000_0001);
      cmd("$2SU7E070102", RSP_OK, 1, 1);
      check("edge address", {24'h0, setup_address_byte}, 32'h0000_007E);
      $display("test address errors done");
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rst = 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_wprot();
      t_write();
      t_read();
      t_syntax();
      t_badaddr();
      final_report();
   end
   // Watchdog well beyond the expected run of about 300 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      final_report();
   end
endmodule
